// >>> hdl/lpsmc_pkg.sv
package lpsmc_pkg;
  // Clock and sequencing times
  localparam int CLK_PERIOD_NS = 40;
  localparam int ENTRY_TIME_NS = 200; // Window before regulator hand-over
  localparam int EXIT_TIME_NS = 400; // Regulator and clock restore time
  localparam int ENTRY_CYC = (ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_CYC = (EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RSTAT = 8'h08;

  // Control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_VAR_LSB = 3;
  localparam int CTRL_VERY_LOW_POWER_RUN_BIT = 5;
  localparam int CTRL_PISO_ACK_BIT = 6;

  // Status register fields
  localparam int STAT_VERY_LOW_POWER_RUN_BIT = 0;
  localparam int STAT_ABORT_BIT = 1;
  localparam int STAT_PINHOLD_BIT = 2;
  localparam int STAT_WKPEND_BIT = 3;
  localparam int STAT_HOLD_BIT = 4;
  localparam int STAT_DBGACK_BIT = 5;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_KIND_LSB = 12;

  // Reset status fields
  localparam int RS_PIN_BIT = 0;
  localparam int RS_WAKE_BIT = 1;

  // Stop mode select and variant encodings
  localparam logic [2:0] SEL_STOP = 3'h0;
  localparam logic [2:0] SEL_VERY_LOW_POWER_STOP = 3'h2;
  localparam logic [2:0] SEL_LLS = 3'h3;
  localparam logic [2:0] SEL_VLLS = 3'h4;
  localparam logic [1:0] VAR_VLLS0 = 2'h0;
  localparam logic [1:0] VAR_VLLS1 = 2'h1;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_ENTRY = 3'h1,
    ST_STOP = 3'h3,
    ST_EXIT = 3'h2,
    ST_WAIT = 3'h6,
    ST_EMU = 3'h7
  } lpsmc_state_t;

  typedef enum logic [2:0] {
    K_STOP = 3'h0,
    K_VERY_LOW_POWER_STOP = 3'h1,
    K_LLS = 3'h2,
    K_VLLS0 = 3'h3,
    K_VLLS1 = 3'h4,
    K_VLLS3 = 3'h5
  } lpsmc_kind_t;
endpackage : lpsmc_pkg

// >>> hdl/lpsmc_top.sv
// Functional notes
// - Deep sleep in VLP run with select 010 or 000 enters VLP stop.
// - Deep sleep in run with select 010 enters VLP stop; exit returns to run.
// - VLP stop keeps the regulator in stop regulation.
// - Async interrupt wakes VLP stop to VLP run unless entered from run.
// - System reset during VLP stop returns to normal run.
// - Low-leakage stop enterable from run or VLP run by deep sleep.
// - Low-leakage stop: regulator in stop regulation, peripherals retained idle.
// - Low-leakage wake returns to run with wakeup interrupt pending.
// - Reset pin in low-leakage stop exits to run, sets pin and wake causes.
// - Three very-low-leakage variants, enterable from run or VLP run.
// - Very-low-leakage stop powers logic off; register contents lost.
// - Very-low-leakage wake returns to run with wakeup interrupt pending.
// - Pins latch on very-low-leakage entry; isolation ack write releases them.
// - Reset pin in very-low-leakage stop exits to run, sets both causes.
// - Secured chip disables debugger power-up handling.
// - Power-up requests answered by matching acks in run, wait and emulated stop modes.
// - Both debug requests turn stop or VLP stop into emulated stop.
// - No debug in leakage stops; debug resumes after low-leakage wake.
// - Very-low-leakage entry powers off debug controls.
// - Deep-stop debug request holds system in reset after deep recovery.
// - Deep-stop debug ack releases the core; cleared by next deep recovery.
// - Interrupt or reset before regulator hand-over aborts entry, sets flag.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module lpsmc_top
  import lpsmc_pkg::*;
#(
  parameter int AW = 8,
  parameter int ENTRY_CYCLES = ENTRY_CYC,
  parameter int EXIT_CYCLES = EXIT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_sleep_entry,
  input wire logic core_deep_sleep_bit,
  input wire logic async_wake_irq,
  input wire logic wakeup_unit_wake,
  input wire logic sys_reset_req,
  input wire logic ext_reset_pin,
  input wire logic chip_secure,
  input wire logic system_powerup_request,
  input wire logic debug_powerup_request,
  output logic system_powerup_ack,
  output logic debug_powerup_ack,
  input wire logic deep_stop_debug_request,
  input wire logic deep_stop_debug_ack,
  output logic regulator_stop,
  output logic clock_gen_enable,
  output logic sys_clock_gate,
  output logic core_clock_enable,
  output logic periph_access_block,
  output logic state_retention,
  output logic logic_power_off,
  output logic pin_latch_hold,
  output logic wakeup_irq_pending,
  output logic core_hold_reset,
  output logic debug_access_enable,
  output logic debug_domain_off
);

  typedef struct packed {
    lpsmc_state_t st;
    lpsmc_kind_t kind;
    logic from_very_low_power_run;
    logic exit_very_low_power_run;
    logic exit_vlls;
    logic exit_wake;
    logic [CNT_W-1:0] cnt;
    logic run_vlp;
    logic [2:0] sel;
    logic [1:0] var_sel;
    logic aborted;
    logic pin_hold;
    logic wk_pend;
    logic hold_core;
    logic dbg_ack;
    logic rs_pin;
    logic rs_wake;
    logic aw_held;
    logic [AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic o_reg_stop;
    logic o_clkgen_off;
    logic o_sysclk_gate;
    logic o_core_clk_off;
    logic o_periph_block;
    logic o_retain;
    logic o_logic_off;
    logic o_dbg_en;
    logic o_dbg_off;
  } lpsmc_regs_t;

  localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(ENTRY_CYCLES - 1);
  localparam logic [CNT_W-1:0] EXIT_LAST = CNT_W'(EXIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  lpsmc_regs_t r_q;
  lpsmc_regs_t r_d;

  // Next-state logic for bus slave, mode sequencer and outputs
  always_comb begin
    logic wr_go;
    logic wr_lo;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_rst;
    logic rst_any;
    logic dbg_both;
    logic lowleak;
    logic vlls;
    logic do_exit;
    logic nlowleak;
    logic nvlls;
    lpsmc_kind_t dk;
    wr_go = 1'b0;
    wr_lo = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_rst = 1'b0;
    rst_any = sys_reset_req | ext_reset_pin;
    dbg_both = system_powerup_request & debug_powerup_request & ~chip_secure;
    lowleak = 1'b0;
    vlls = 1'b0;
    do_exit = 1'b0;
    nlowleak = 1'b0;
    nvlls = 1'b0;
    dk = K_STOP;
    r_d = r_q;

    // Write address and data captured independently
    if (s_axi_awvalid && !r_q.aw_held) begin
      r_d.aw_held = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_q.w_held) begin
      r_d.w_held = 1'b1;
      r_d.wdata = s_axi_wdata;
      r_d.wstrb = s_axi_wstrb;
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end
    wr_go = r_q.aw_held & r_q.w_held & ~r_q.bvalid;
    wr_lo = wr_go & r_q.wstrb[0];
    hit_ctrl = (r_q.aw_addr[AW-1:2] == OFF_CTRL[AW-1:2]);
    hit_stat = (r_q.aw_addr[AW-1:2] == OFF_STATUS[AW-1:2]);
    hit_rst = (r_q.aw_addr[AW-1:2] == OFF_RSTAT[AW-1:2]);
    if (wr_go) begin
      r_d.aw_held = 1'b0;
      r_d.w_held = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = (hit_ctrl | hit_stat | hit_rst) ? RESP_OKAY : RESP_SLVERR;
    end

    // Register write effects; clears first so hardware sets win
    if (wr_lo && hit_ctrl) begin
      r_d.sel = r_q.wdata[CTRL_SEL_LSB +: 3];
      r_d.var_sel = r_q.wdata[CTRL_VAR_LSB +: 2];
      if (r_q.st == ST_RUN) begin
        r_d.run_vlp = r_q.wdata[CTRL_VERY_LOW_POWER_RUN_BIT];
      end
      if (r_q.wdata[CTRL_PISO_ACK_BIT]) begin
        r_d.pin_hold = 1'b0;
      end
    end
    if (wr_lo && hit_stat) begin
      if (r_q.wdata[STAT_ABORT_BIT]) begin
        r_d.aborted = 1'b0;
      end
      if (r_q.wdata[STAT_WKPEND_BIT]) begin
        r_d.wk_pend = 1'b0;
      end
    end
    if (wr_lo && hit_rst) begin
      if (r_q.wdata[RS_PIN_BIT]) begin
        r_d.rs_pin = 1'b0;
      end
      if (r_q.wdata[RS_WAKE_BIT]) begin
        r_d.rs_wake = 1'b0;
      end
    end

    // Read channel, one access at a time
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r_q.rvalid) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = RESP_OKAY;
      r_d.rdata = 32'h0000_0000;
      if (s_axi_araddr[AW-1:2] == OFF_CTRL[AW-1:2]) begin
        r_d.rdata[CTRL_SEL_LSB +: 3] = r_q.sel;
        r_d.rdata[CTRL_VAR_LSB +: 2] = r_q.var_sel;
        r_d.rdata[CTRL_VERY_LOW_POWER_RUN_BIT] = r_q.run_vlp;
      end else if (s_axi_araddr[AW-1:2] == OFF_STATUS[AW-1:2]) begin
        r_d.rdata[STAT_VERY_LOW_POWER_RUN_BIT] = r_q.run_vlp;
        r_d.rdata[STAT_ABORT_BIT] = r_q.aborted;
        r_d.rdata[STAT_PINHOLD_BIT] = r_q.pin_hold;
        r_d.rdata[STAT_WKPEND_BIT] = r_q.wk_pend;
        r_d.rdata[STAT_HOLD_BIT] = r_q.hold_core;
        r_d.rdata[STAT_DBGACK_BIT] = r_q.dbg_ack;
        r_d.rdata[STAT_STATE_LSB +: 3] = r_q.st;
        r_d.rdata[STAT_KIND_LSB +: 3] = r_q.kind;
      end else if (s_axi_araddr[AW-1:2] == OFF_RSTAT[AW-1:2]) begin
        r_d.rdata[RS_PIN_BIT] = r_q.rs_pin;
        r_d.rdata[RS_WAKE_BIT] = r_q.rs_wake;
      end else begin
        r_d.rresp = RESP_SLVERR;
      end
    end

    // Stop kind decode from select and variant
    if (r_q.sel == SEL_LLS) begin
      dk = K_LLS;
    end else if (r_q.sel == SEL_VLLS) begin
      if (r_q.var_sel == VAR_VLLS0) begin
        dk = K_VLLS0;
      end else if (r_q.var_sel == VAR_VLLS1) begin
        dk = K_VLLS1;
      end else begin
        dk = K_VLLS3;
      end
    end else if (r_q.run_vlp) begin
      dk = K_VERY_LOW_POWER_STOP;
    end else if (r_q.sel == SEL_VERY_LOW_POWER_STOP) begin
      dk = K_VERY_LOW_POWER_STOP;
    end else begin
      dk = K_STOP;
    end
    vlls = (r_q.kind == K_VLLS0) | (r_q.kind == K_VLLS1) | (r_q.kind == K_VLLS3);
    lowleak = (r_q.kind == K_LLS) | vlls;

    // Reset pin always records its cause
    if (ext_reset_pin) begin
      r_d.rs_pin = 1'b1;
    end

    // Mode sequencer
    case (r_q.st)
      ST_RUN: begin
        if (rst_any) begin
          r_d.run_vlp = 1'b0;
        end else if (core_sleep_entry && !r_q.hold_core) begin
          if (!core_deep_sleep_bit) begin
            r_d.st = ST_WAIT;
          end else begin
            r_d.kind = dk;
            r_d.from_very_low_power_run = r_q.run_vlp;
            if ((dk == K_STOP || dk == K_VERY_LOW_POWER_STOP) && dbg_both) begin
              r_d.st = ST_EMU;
            end else begin
              r_d.st = ST_ENTRY;
              r_d.cnt = '0;
            end
          end
        end
      end
      ST_WAIT: begin
        if (rst_any) begin
          r_d.st = ST_RUN;
          r_d.run_vlp = 1'b0;
        end else if (async_wake_irq) begin
          r_d.st = ST_RUN;
        end
      end
      ST_EMU: begin
        if (rst_any) begin
          r_d.st = ST_RUN;
          r_d.run_vlp = 1'b0;
        end else if (async_wake_irq) begin
          r_d.st = ST_RUN;
        end
      end
      ST_ENTRY: begin
        if (rst_any || async_wake_irq || wakeup_unit_wake) begin
          r_d.st = ST_RUN;
          r_d.aborted = 1'b1;
          if (rst_any) begin
            r_d.run_vlp = 1'b0;
          end
        end else if (r_q.cnt == ENTRY_LAST) begin
          r_d.st = ST_STOP;
          if (vlls) begin
            r_d.pin_hold = 1'b1;
          end
        end else begin
          r_d.cnt = r_q.cnt + CNT_ONE;
        end
      end
      ST_STOP: begin
        r_d.exit_very_low_power_run = 1'b0;
        r_d.exit_wake = 1'b0;
        r_d.exit_vlls = vlls;
        if (rst_any) begin
          do_exit = 1'b1;
          r_d.pin_hold = 1'b0;
          if (ext_reset_pin && lowleak) begin
            r_d.rs_wake = 1'b1;
          end
        end else if (!lowleak && async_wake_irq) begin
          do_exit = 1'b1;
          r_d.exit_very_low_power_run = (r_q.kind == K_VERY_LOW_POWER_STOP) & r_q.from_very_low_power_run;
        end else if (lowleak && wakeup_unit_wake) begin
          do_exit = 1'b1;
          r_d.exit_wake = 1'b1;
        end
        if (do_exit) begin
          r_d.st = ST_EXIT;
          r_d.cnt = '0;
        end
      end
      ST_EXIT: begin
        if (r_q.cnt == EXIT_LAST) begin
          r_d.st = ST_RUN;
          r_d.run_vlp = r_q.exit_very_low_power_run;
          if (r_q.exit_wake) begin
            r_d.wk_pend = 1'b1;
          end
          if (r_q.exit_vlls) begin
            r_d.sel = SEL_STOP;
            r_d.var_sel = VAR_VLLS0;
            r_d.dbg_ack = 1'b0;
            r_d.hold_core = deep_stop_debug_request;
          end
        end else begin
          r_d.cnt = r_q.cnt + CNT_ONE;
        end
      end
      default: begin
        r_d.st = ST_RUN;
      end
    endcase

    // Debugger acknowledge sets the bit and frees a held core
    if (deep_stop_debug_ack && !chip_secure) begin
      r_d.dbg_ack = 1'b1;
    end
    if (r_q.hold_core && r_q.dbg_ack) begin
      r_d.hold_core = 1'b0;
    end

    // Registered power and clock controls from the next state
    nvlls = (r_d.kind == K_VLLS0) | (r_d.kind == K_VLLS1) | (r_d.kind == K_VLLS3);
    nlowleak = (r_d.kind == K_LLS) | nvlls;
    r_d.o_reg_stop = (r_d.st == ST_STOP)
                   | ((r_d.st == ST_RUN || r_d.st == ST_WAIT) & r_d.run_vlp)
                   | ((r_d.st == ST_ENTRY) & r_d.from_very_low_power_run)
                   | ((r_d.st == ST_EXIT) & r_d.exit_very_low_power_run);
    r_d.o_clkgen_off = (r_d.st == ST_STOP);
    r_d.o_sysclk_gate = (r_d.st == ST_STOP) | (r_d.st == ST_EMU);
    r_d.o_core_clk_off = (r_d.st != ST_RUN) & (r_d.st != ST_EMU);
    r_d.o_periph_block = (r_d.st == ST_EMU);
    r_d.o_retain = (r_d.st == ST_STOP) & (r_d.kind == K_LLS);
    r_d.o_logic_off = (r_d.st == ST_STOP) & nvlls;
    r_d.o_dbg_off = (r_d.st == ST_STOP) & nvlls;
    r_d.o_dbg_en = ~chip_secure & ~((r_d.st == ST_STOP) & nlowleak);
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Bus handshakes
  assign s_axi_awready = ~r_q.aw_held;
  assign s_axi_wready = ~r_q.w_held;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = ~r_q.rvalid;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;

  // Debugger power-up acknowledges in run, wait and emulated stop modes
  assign system_powerup_ack = system_powerup_request & ~chip_secure
                            & ((r_q.st == ST_RUN) | (r_q.st == ST_WAIT) | (r_q.st == ST_EMU));
  assign debug_powerup_ack = debug_powerup_request & ~chip_secure
                           & ((r_q.st == ST_RUN) | (r_q.st == ST_WAIT) | (r_q.st == ST_EMU));

  // Power, clock and pin controls
  assign regulator_stop = r_q.o_reg_stop;
  assign clock_gen_enable = ~r_q.o_clkgen_off;
  assign sys_clock_gate = r_q.o_sysclk_gate;
  assign core_clock_enable = ~r_q.o_core_clk_off;
  assign periph_access_block = r_q.o_periph_block;
  assign state_retention = r_q.o_retain;
  assign logic_power_off = r_q.o_logic_off;
  assign pin_latch_hold = r_q.pin_hold;
  assign wakeup_irq_pending = r_q.wk_pend;
  assign core_hold_reset = r_q.hold_core;
  assign debug_access_enable = r_q.o_dbg_en;
  assign debug_domain_off = r_q.o_dbg_off;

endmodule : lpsmc_top
`default_nettype wire

// >>> sim/lpsmc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module lpsmc_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_secure,
  input wire logic system_powerup_request,
  input wire logic debug_powerup_request,
  input wire logic system_powerup_ack,
  input wire logic debug_powerup_ack,
  input wire logic debug_access_enable,
  input wire logic logic_power_off,
  input wire logic regulator_stop,
  input wire logic debug_domain_off,
  input wire logic state_retention,
  input wire logic periph_access_block,
  input wire logic clock_gen_enable,
  input wire logic sys_clock_gate,
  input wire logic core_clock_enable,
  input wire logic ext_reset_pin,
  input wire logic pin_latch_hold,
  input wire logic wakeup_unit_wake,
  input wire logic wakeup_irq_pending,
  input wire logic core_hold_reset,
  input wire logic deep_stop_debug_ack
);
  // One clock domain for every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ack_sys_a: assert property (system_powerup_ack |-> system_powerup_request && !chip_secure)
    else $error("system ack without open request");
  ack_dbg_a: assert property (debug_powerup_ack |-> debug_powerup_request && !chip_secure)
    else $error("debug ack without open request");
  secure_dbg_a: assert property (chip_secure |=> !debug_access_enable)
    else $error("debug access left on while secure");
  deep_off_a: assert property (logic_power_off |-> regulator_stop && debug_domain_off && !debug_access_enable)
    else $error("deep stop outputs inconsistent");
  retain_state_a: assert property (state_retention |-> regulator_stop && !logic_power_off && !debug_access_enable)
    else $error("retention stop outputs inconsistent");
  emu_clock_a: assert property (periph_access_block |-> !regulator_stop && clock_gen_enable && sys_clock_gate && core_clock_enable)
    else $error("emulated stop clocking wrong");
  pin_exit_a: assert property (ext_reset_pin && (logic_power_off || state_retention) |-> ##[1:2] !(logic_power_off || state_retention || pin_latch_hold))
    else $error("reset pin did not end leakage stop");
  leak_wake_a: assert property (wakeup_unit_wake && state_retention |-> ##[1:20] wakeup_irq_pending)
    else $error("wake pending missing after retention wake");
  hold_rel_a: assert property (core_hold_reset && deep_stop_debug_ack && !chip_secure |-> ##[1:3] !core_hold_reset)
    else $error("core hold not released by ack");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  // Main scenarios reached
  cover property (logic_power_off);
  cover property (state_retention);
  cover property (periph_access_block);
  cover property (core_hold_reset);
endmodule : lpsmc_checker

bind lpsmc_top lpsmc_checker i_lpsmc_checker (.*);
`default_nettype wire

// >>> sim/lpsmc_core_dbg_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpsmc_core_dbg_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_cmd,
  input wire logic core_hold_reset,
  output logic core_sleep_entry,
  output logic deep_stop_debug_ack
);
  logic [1:0] seen_q;
  // Core sleeps on command; debugger acks a held core three cycles late
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_sleep_entry <= 1'b0;
      seen_q <= 2'h0;
      deep_stop_debug_ack <= 1'b0;
    end else begin
      core_sleep_entry <= sleep_cmd && !core_hold_reset;
      seen_q <= {seen_q[0], core_hold_reset};
      deep_stop_debug_ack <= seen_q[1] && core_hold_reset;
    end
  end
endmodule : lpsmc_core_dbg_model
`default_nettype wire

// >>> sim/lpsmc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lpsmc_top_tb;
  import lpsmc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, ev = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_cmd = 1'b0, chip_secure = 1'b0;
  logic system_powerup_request = 1'b0, debug_powerup_request = 1'b0;
  logic deep_stop_debug_request = 1'b0, core_deep_sleep_bit = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic core_sleep_entry, deep_stop_debug_ack, system_powerup_ack, debug_powerup_ack;
  logic regulator_stop, clock_gen_enable, sys_clock_gate, core_clock_enable;
  logic periph_access_block, state_retention, logic_power_off, pin_latch_hold;
  logic wakeup_irq_pending, core_hold_reset, debug_access_enable, debug_domain_off;
  int fails = 0, checked = 0, cyc = 0;

  lpsmc_top #(.ENTRY_CYCLES(3), .EXIT_CYCLES(4)) i_lpsmc_top (.*, .async_wake_irq(ev[0]),
    .wakeup_unit_wake(ev[1]), .sys_reset_req(ev[2]), .ext_reset_pin(ev[3]));
  lpsmc_core_dbg_model i_lpsmc_core_dbg_model (.*);

  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      test_done;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, RESP_OKAY);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] rd, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    cmp(s_axi_rresp, er);
  endtask : axr

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic sleep;
    @(posedge clk);
    sleep_cmd <= 1'b1;
    @(posedge clk);
    sleep_cmd <= 1'b0;
  endtask : sleep

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask : pulse

  function automatic logic pick(input int s);
    case (s)
      0: return clock_gen_enable;
      1: return core_clock_enable;
      2: return core_hold_reset;
      default: return periph_access_block;
    endcase
  endfunction : pick

  // Bounded wait for an output level, then judge it
  task automatic wt(input int s, input logic v);
    for (int i = 0; i < 60 && pick(s) !== v; i++) @(posedge clk);
    cmp(pick(s), v);
  endtask : wt

  task automatic t_basic;
    logic [31:0] rd;
    axr(8'h0C, rd, RESP_SLVERR);
    cmp(rd, 32'h0);
    system_powerup_request <= 1'b1;
    debug_powerup_request <= 1'b1;
    tick(2);
    cmp({system_powerup_ack, debug_powerup_ack, debug_access_enable}, 3'h7);
    chip_secure <= 1'b1;
    tick(2);
    cmp({system_powerup_ack, debug_powerup_ack, debug_access_enable}, 3'h0);
    chip_secure <= 1'b0;
    system_powerup_request <= 1'b0;
    debug_powerup_request <= 1'b0;
    $display("basic done");
  endtask : t_basic

  task automatic t_vlp;
    logic [31:0] rd;
    axw(OFF_CTRL, 32'h02);
    sleep;
    wt(0, 1'b0);
    cmp(regulator_stop, 1'b1);
    axr(OFF_STATUS, rd, RESP_OKAY);
    cmp(rd[14:12], 3'h1);
    pulse(0);
    wt(1, 1'b1);
    axr(OFF_STATUS, rd, RESP_OKAY);
    cmp(rd[0], 1'b0);
    axw(OFF_CTRL, 32'h20);
    for (int r = 0; r < 2; r++) begin
      sleep;
      wt(0, 1'b0);
      pulse(r == 0 ? 0 : 2);
      wt(1, 1'b1);
      axr(OFF_STATUS, rd, RESP_OKAY);
      cmp(rd[0], r == 0);
    end
    $display("low power stop done");
  endtask : t_vlp

  task automatic t_leak;
    logic [31:0] rd;
    for (int r = 0; r < 2; r++) begin
      axw(OFF_CTRL, r == 0 ? 32'h23 : 32'h03);
      sleep;
      wt(0, 1'b0);
      cmp({state_retention, regulator_stop, debug_access_enable}, 3'h6);
      pulse(r == 0 ? 1 : 3);
      wt(1, 1'b1);
      cmp(debug_access_enable, 1'b1);
      if (r == 0) begin
        cmp(wakeup_irq_pending, 1'b1);
        axw(OFF_STATUS, 32'h08);
      end else begin
        axr(OFF_RSTAT, rd, RESP_OKAY);
        cmp(rd, 32'h3);
        axw(OFF_RSTAT, 32'h03);
      end
    end
    $display("retention stop done");
  endtask : t_leak

  task automatic t_deep;
    logic [31:0] rd;
    for (int v = 0; v < 3; v++) begin
      deep_stop_debug_request <= (v == 1);
      axw(OFF_CTRL, 32'h04 | (v << 3));
      sleep;
      wt(0, 1'b0);
      cmp({logic_power_off, regulator_stop, pin_latch_hold, debug_domain_off}, 4'hF);
      axr(OFF_STATUS, rd, RESP_OKAY);
      cmp(rd[14:12], 3 + v);
      pulse(v == 2 ? 3 : 1);
      if (v == 1) begin
        wt(2, 1'b1);
        wt(2, 1'b0);
      end
      wt(1, 1'b1);
      if (v == 2) begin
        axr(OFF_RSTAT, rd, RESP_OKAY);
        cmp({rd[1:0], pin_latch_hold}, 3'h6);
      end else begin
        cmp({wakeup_irq_pending, pin_latch_hold}, 2'h3);
        axw(OFF_CTRL, 32'h40);
        cmp(pin_latch_hold, 1'b0);
      end
    end
    $display("deep stop done");
  endtask : t_deep

  task automatic t_emu;
    system_powerup_request <= 1'b1;
    debug_powerup_request <= 1'b1;
    core_deep_sleep_bit <= 1'b0;
    axw(OFF_CTRL, 32'h00);
    sleep;
    wt(1, 1'b0);
    cmp({sys_clock_gate, clock_gen_enable, periph_access_block, system_powerup_ack,
      debug_powerup_ack}, 5'h0B);
    pulse(0);
    wt(1, 1'b1);
    core_deep_sleep_bit <= 1'b1;
    sleep;
    wt(3, 1'b1);
    cmp({sys_clock_gate, clock_gen_enable, regulator_stop, core_clock_enable,
      system_powerup_ack, debug_powerup_ack}, 6'h37);
    pulse(0);
    wt(3, 1'b0);
    system_powerup_request <= 1'b0;
    debug_powerup_request <= 1'b0;
    $display("emulated stop done");
  endtask : t_emu

  task automatic t_abort;
    logic [31:0] rd;
    sleep;
    pulse(0);
    tick(2);
    cmp({core_clock_enable, clock_gen_enable}, 2'h3);
    axr(OFF_STATUS, rd, RESP_OKAY);
    cmp(rd[1], 1'b1);
    $display("abort done");
  endtask : t_abort

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_basic;
    t_vlp;
    t_leak;
    t_deep;
    t_emu;
    t_abort;
    test_done;
  end
endmodule : lpsmc_top_tb
`default_nettype wire
